// *** common/lrb_cfg.svh ***
// Purpose: offsets, field positions, reset values for the response buffer register block
// Assumes: byte-wide registers on a plain port
// Notes: offsets are local choices
`ifndef LRB_CFG_SVH
`define LRB_CFG_SVH
`define LRB_ADDR_W 4
`define LRB_OFF_LEN 4'h0
`define LRB_OFF_IDENT 4'h1
`define LRB_OFF_SEL 4'h2
`define LRB_OFF_DATA 4'h3
`define LRB_OFF_MODE 4'h4
`define LRB_OFF_STAT 4'h5
`define LRB_OFF_CLR 4'h6
`define LRB_OFF_IEN 4'h7
`define LRB_RX_LSB 0
`define LRB_TX_LSB 4
`define LRB_ID_LEN_LSB 4
`define LRB_PAR_LSB 6
`define LRB_HOLD_BIT 3
`define LRB_MAX_BYTES 4'h8
`define LRB_RST_BYTE 8'h00
`define LRB_ST_TX 0
`define LRB_ST_RX 1
`define LRB_ST_ERR 2
`endif

// *** common/lrb_pkg.sv ***
// Purpose: types for the response buffer register block
// Assumes: none
// Notes: mode encodings
package lrb_pkg;
  typedef enum logic [1:0] {
    LRB_MODE_UART,
    LRB_MODE_LIN13,
    LRB_MODE_LIN21
  } lrb_mode_t;
endpackage

// *** verilog/lrb_buffer.sv ***
// Purpose: eight-entry response byte store with one port each for software and engine
// Assumes: engine and software never write the same entry in one cycle
// Notes: software write wins on a clash
`timescale 1ns/100ps
`default_nettype none
module lrb_buffer #(
  parameter int DEPTH = 8,
  parameter int IW = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_we,
  input wire logic [IW-1:0] sw_idx,
  input wire logic [7:0] sw_wdata,
  output logic [7:0] sw_rdata,
  input wire logic eng_we,
  input wire logic [IW-1:0] eng_idx,
  input wire logic [7:0] eng_wdata,
  output logic [7:0] eng_rdata
);
  logic [7:0] mem_r [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_r[g] <= 8'h00;
        end else if (sw_we && sw_idx == IW'(g)) begin
          mem_r[g] <= sw_wdata;
        end else if (eng_we && eng_idx == IW'(g)) begin
          mem_r[g] <= eng_wdata;
        end
      end
    end
  endgenerate
  assign sw_rdata = mem_r[sw_idx];
  assign eng_rdata = mem_r[eng_idx];
endmodule // lrb_buffer
`default_nettype wire

// *** verilog/lrb_regs.sv ***
// Purpose: length, identifier, index select and data port registers of a LIN/UART controller
// Assumes: frame engine on the same clock; engine pulses are single cycle
// Notes: status sticky, write-one clear via separate clear register
//
// Contract
// - LIN rx count from field, clamped to eight
// - legacy length code gives 2,2,4,8 bytes
// - legacy mode uses identifier bits 3:0
// - newer mode six-bit identifier, length register only
// - parity bits 7:6 used in LIN
// - hold bit zero means auto increment
// - index bits 2:0 pick buffer entry
// - LIN data port accesses indexed buffer
// - UART data port is single byte
// - select and data reset to zero
// - LIN tx count from field, clamped
// - UART data write/read clears flags
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "lrb_cfg.svh"
module lrb_regs
  import lrb_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int IW = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`LRB_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic eng_tx_done,
  input wire logic eng_rx_done,
  input wire logic eng_error,
  input wire logic eng_we,
  input wire logic [IW-1:0] eng_idx,
  input wire logic [7:0] eng_wdata,
  output logic [7:0] eng_rdata,
  input wire logic [7:0] uart_rx_byte,
  input wire logic uart_rx_load,
  output logic [1:0] mode,
  output logic [3:0] rx_byte_count,
  output logic [3:0] tx_byte_count,
  output logic [5:0] frame_ident,
  output logic [1:0] ident_parity,
  output logic [7:0] uart_tx_byte,
  output logic uart_tx_start
);
  logic [7:0] frame_length_select_r;
  logic [7:0] frame_identifier_r;
  logic index_hold_r;
  logic [IW-1:0] buffer_index_r;
  logic [7:0] port_byte_r;
  lrb_mode_t mode_r;
  logic [2:0] status_r;
  logic [2:0] ien_r;
  logic [7:0] buf_sw_rdata;
  logic [7:0] eng_rdata_nxt;
  logic [3:0] rx_cnt_nxt;
  logic [3:0] tx_cnt_nxt;
  logic [3:0] legacy_bytes;
  logic [5:0] ident_nxt;
  logic is_lin;
  logic data_wr;
  logic data_rd;
  logic [2:0] stat_set;
  logic [2:0] stat_clr;
  logic [7:0] rdata_nxt;

  assign is_lin = (mode_r != LRB_MODE_UART);
  assign data_wr = wr && addr == `LRB_OFF_DATA;
  assign data_rd = rd && addr == `LRB_OFF_DATA;

  lrb_buffer #(
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .sw_we(data_wr && is_lin),
    .sw_idx(buffer_index_r),
    .sw_wdata(wdata),
    .sw_rdata(buf_sw_rdata),
    .eng_we(eng_we && is_lin),
    .eng_idx(eng_idx),
    .eng_wdata(eng_wdata),
    .eng_rdata(eng_rdata_nxt)
  );

  // byte counts seen by the frame engine
  always_comb begin
    case (frame_identifier_r[`LRB_ID_LEN_LSB +: 2])
      2'b10: legacy_bytes = 4'h4;
      2'b11: legacy_bytes = 4'h8;
      default: legacy_bytes = 4'h2;
    endcase
    rx_cnt_nxt = frame_length_select_r[`LRB_RX_LSB +: 4];
    tx_cnt_nxt = frame_length_select_r[`LRB_TX_LSB +: 4];
    if (rx_cnt_nxt > `LRB_MAX_BYTES) begin
      rx_cnt_nxt = `LRB_MAX_BYTES;
    end
    if (tx_cnt_nxt > `LRB_MAX_BYTES) begin
      tx_cnt_nxt = `LRB_MAX_BYTES;
    end
    ident_nxt = frame_identifier_r[5:0];
    case (mode_r)
      LRB_MODE_LIN13: begin
        rx_cnt_nxt = legacy_bytes;
        tx_cnt_nxt = legacy_bytes;
        ident_nxt = {2'b00, frame_identifier_r[3:0]};
      end
      LRB_MODE_LIN21: begin
      end
      default: begin
        rx_cnt_nxt = 4'h0;
        tx_cnt_nxt = 4'h0;
        ident_nxt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_byte_count <= 4'h0;
      tx_byte_count <= 4'h0;
      frame_ident <= 6'h00;
      ident_parity <= 2'b00;
      mode <= 2'b00;
      eng_rdata <= 8'h00;
    end else begin
      rx_byte_count <= rx_cnt_nxt;
      tx_byte_count <= tx_cnt_nxt;
      frame_ident <= ident_nxt;
      ident_parity <= is_lin ? frame_identifier_r[`LRB_PAR_LSB +: 2] : 2'b00;
      mode <= mode_r;
      eng_rdata <= eng_rdata_nxt;
    end
  end

  // plain configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_length_select_r <= `LRB_RST_BYTE;
      frame_identifier_r <= `LRB_RST_BYTE;
      mode_r <= LRB_MODE_UART;
      ien_r <= 3'b000;
    end else if (wr) begin
      case (addr)
        `LRB_OFF_LEN: frame_length_select_r <= wdata;
        `LRB_OFF_IDENT: frame_identifier_r <= wdata;
        `LRB_OFF_MODE: begin
          case (wdata[1:0])
            2'b01: mode_r <= LRB_MODE_LIN13;
            2'b10: mode_r <= LRB_MODE_LIN21;
            default: mode_r <= LRB_MODE_UART;
          endcase
        end
        `LRB_OFF_IEN: ien_r <= wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // index select: explicit write or auto increment on data access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_hold_r <= 1'b0;
      buffer_index_r <= '0;
    end else if (wr && addr == `LRB_OFF_SEL) begin
      index_hold_r <= wdata[`LRB_HOLD_BIT];
      buffer_index_r <= wdata[IW-1:0];
    end else if (is_lin && !index_hold_r && (data_wr || data_rd)) begin
      buffer_index_r <= buffer_index_r + 1'b1;
    end
  end

  // uart single data byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_byte_r <= `LRB_RST_BYTE;
      uart_tx_byte <= 8'h00;
      uart_tx_start <= 1'b0;
    end else begin
      uart_tx_start <= data_wr && !is_lin;
      if (data_wr && !is_lin) begin
        uart_tx_byte <= wdata;
      end
      if (uart_rx_load && !is_lin) begin
        port_byte_r <= uart_rx_byte;
      end
    end
  end

  // sticky status, set beats clear
  always_comb begin
    stat_set = 3'b000;
    stat_set[`LRB_ST_TX] = eng_tx_done;
    stat_set[`LRB_ST_RX] = eng_rx_done;
    stat_set[`LRB_ST_ERR] = eng_error;
    stat_clr = (wr && addr == `LRB_OFF_CLR) ? wdata[2:0] : 3'b000;
    if (data_wr && !is_lin) begin
      stat_clr[`LRB_ST_TX] = 1'b1;
    end
    if (data_rd && !is_lin) begin
      stat_clr[`LRB_ST_RX] = 1'b1;
      stat_clr[`LRB_ST_ERR] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= 3'b000;
      irq <= 1'b0;
    end else begin
      status_r <= (status_r & ~stat_clr) | stat_set;
      irq <= |(((status_r & ~stat_clr) | stat_set) & ien_r);
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 8'h00;
    case (addr)
      `LRB_OFF_LEN: rdata_nxt = frame_length_select_r;
      `LRB_OFF_IDENT: rdata_nxt = frame_identifier_r;
      `LRB_OFF_SEL: rdata_nxt = {4'h0, index_hold_r, buffer_index_r};
      `LRB_OFF_DATA: rdata_nxt = is_lin ? buf_sw_rdata : port_byte_r;
      `LRB_OFF_MODE: rdata_nxt = {6'h00, mode_r};
      `LRB_OFF_STAT: rdata_nxt = {5'h00, status_r};
      `LRB_OFF_IEN: rdata_nxt = {5'h00, ien_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rdata_nxt : 8'h00;
    end
  end
endmodule // lrb_regs
`default_nettype wire

// *** tb/lrb_chk.sv ***
// Purpose: port checker for lrb_regs
// Assumes: one clock, rst async high
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module lrb_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [1:0] mode,
  input wire logic [3:0] rx_byte_count,
  input wire logic [3:0] tx_byte_count,
  input wire logic [5:0] frame_ident,
  input wire logic [1:0] ident_parity,
  input wire logic uart_tx_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire lw = wr && addr == 4'h0 && mode == 2'h2;
  a_rx_clamp: assert property (lw && wdata[3:0] > 4'h8 |-> ##[1:2] rx_byte_count == 4'h8)
    else $error("rx clamp");
  a_tx_clamp: assert property (lw && wdata[7:4] > 4'h8 |-> ##[1:2] tx_byte_count == 4'h8)
    else $error("tx clamp");
  a_uart_quiet: assert property ((mode == 2'h0)[*3] |-> {frame_ident, ident_parity} == 8'h00)
    else $error("uart fields");
  a_legacy_len: assert property ((mode == 2'h1)[*3] |-> rx_byte_count inside {4'h2, 4'h4, 4'h8})
    else $error("legacy length");
  a_legacy_ident: assert property ((mode == 2'h1)[*3] |-> frame_ident[5:4] == 2'h0)
    else $error("legacy ident");
  a_uart_send: assert property (wr && addr == 4'h3 && mode == 2'h0 |-> ##[1:2] uart_tx_start)
    else $error("no send");
  a_send_pulse: assert property (uart_tx_start |=> !uart_tx_start)
    else $error("send pulse");
  a_sel_zero: assert property (rd && addr == 4'h2 |=> rdata[7:4] == 4'h0)
    else $error("select upper");
  c_lin: cover property (lw);
  c_send: cover property (uart_tx_start);
  c_legacy: cover property (mode == 2'h1 && rx_byte_count == 4'h8);
endmodule // lrb_chk
bind lrb_regs lrb_chk u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .mode, .rx_byte_count,
  .tx_byte_count, .frame_ident, .ident_parity, .uart_tx_start);
`default_nettype wire

// *** tb/lrb_eng.sv ***
// Purpose: frame engine stand-in
// Assumes: one-cycle pulses after a rising edge
// Notes: released data shows the inverse
`timescale 1ns/100ps
`default_nettype none
module lrb_eng (
  input wire logic clk,
  output logic [2:0] ev,
  output logic we,
  output logic [2:0] idx,
  output logic [7:0] wd,
  output logic rxl
);
  initial {ev, we, idx, wd, rxl} = '0;
  task automatic fire(input logic [2:0] e, input logic w, input logic [2:0] i, input logic [7:0] d, input logic l);
    {ev, we, idx, wd, rxl} <= {e, w, i, d, l};
    @(posedge clk);
    {ev, we, rxl, wd} <= {5'h00, ~d};
    @(posedge clk);
  endtask
endmodule // lrb_eng
`default_nettype wire

// *** tb/lrb_regs_tb.sv ***
// Purpose: bench for lrb_regs
// Assumes: reads answered next cycle
// Notes: read results checked from a queue
`timescale 1ns/100ps
`default_nettype none
module lrb_regs_tb import lrb_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, irq, uart_tx_start, we, rxl;
  logic [3:0] addr = 4'h0, rx_byte_count, tx_byte_count;
  logic [7:0] wdata = 8'h00, v, rdata, uart_tx_byte, wd, er, b[8], exp_q[$];
  logic [5:0] frame_ident;
  logic [1:0] mode, ident_parity;
  logic [2:0] ev, idx;
  integer fails = 0, comparisons = 0, seed = 32'h8513_cb9a, i;
  lrb_eng u_eng (.clk, .ev, .we, .idx, .wd, .rxl);
  lrb_regs u_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .irq, .eng_tx_done(ev[0]), .eng_rx_done(ev[1]),
    .eng_error(ev[2]), .eng_we(we), .eng_idx(idx), .eng_wdata(wd), .eng_rdata(er), .uart_rx_byte(wd),
    .uart_rx_load(rxl), .mode, .rx_byte_count, .tx_byte_count, .frame_ident, .ident_parity, .uart_tx_byte,
    .uart_tx_start);
  initial forever #25 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    {wr, rd, addr, wdata} <= {w, r, a, d};
    @(posedge clk);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk("rdata", rdata, exp_q.pop_front());
  end
  initial begin
    #1000000;
    fails++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdx(4'h2, 8'h00);
    rdx(4'h3, 8'h00);
    rdx(4'h8, 8'h00);
    bus(1'b1, 1'b0, 4'h4, {6'h00, LRB_MODE_LIN21});
    bus(1'b1, 1'b0, 4'h2, 8'h07);
    for (i = 0; i < 8; i++) begin
      b[(i + 7) % 8] = 8'($random(seed));
      bus(1'b1, 1'b0, 4'h3, b[(i + 7) % 8]);
    end
    rdx(4'h2, 8'h07);
    idle(1);
    u_eng.fire(3'h0, 1'b1, 3'h5, 8'hc3, 1'b0);
    b[5] = 8'hc3;
    for (i = 0; i < 8; i++) rdx(4'h3, b[(i + 7) % 8]);
    chk("eng_rdata", er, 8'hc3);
    bus(1'b1, 1'b0, 4'h2, 8'h0a);
    rdx(4'h3, b[2]);
    rdx(4'h3, b[2]);
    rdx(4'h2, 8'h0a);
    $display("buffer test done");
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h9f : 8'($random(seed));
      bus(1'b1, 1'b0, 4'h0, v);
      bus(1'b1, 1'b0, 4'h1, v);
      idle(2);
      chk("rx", 8'(rx_byte_count), v[3:0] > 4'h8 ? 8'h08 : 8'(v[3:0]));
      chk("tx", 8'(tx_byte_count), v[7:4] > 4'h8 ? 8'h08 : 8'(v[7:4]));
      chk("id", {ident_parity, frame_ident}, v);
    end
    bus(1'b1, 1'b0, 4'h4, {6'h00, LRB_MODE_LIN13});
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 1'b0, 4'h1, {2'h2, 2'(i), 4'ha});
      idle(2);
      chk("rx13", 8'(rx_byte_count), i < 2 ? 8'h02 : (i == 2 ? 8'h04 : 8'h08));
      chk("id13", 8'(frame_ident), 8'h0a);
    end
    $display("count test done");
    bus(1'b1, 1'b0, 4'h4, {6'h00, LRB_MODE_UART});
    bus(1'b1, 1'b0, 4'h7, 8'h07);
    bus(1'b1, 1'b0, 4'h3, 8'h5a);
    idle(2);
    chk("txb", uart_tx_byte, 8'h5a);
    u_eng.fire(3'h1, 1'b0, 3'h0, 8'h3c, 1'b1);
    idle(1);
    chk("irq", 8'(irq), 8'h01);
    bus(1'b1, 1'b0, 4'h3, 8'h11);
    idle(2);
    chk("irq", 8'(irq), 8'h00);
    u_eng.fire(3'h6, 1'b0, 3'h0, 8'h00, 1'b0);
    rdx(4'h3, 8'h3c);
    idle(2);
    chk("irq", 8'(irq), 8'h00);
    bus(1'b1, 1'b0, 4'h7, 8'h00);
    idle(1);
    u_eng.fire(3'h4, 1'b0, 3'h0, 8'h00, 1'b0);
    idle(1);
    chk("irq", 8'(irq), 8'h00);
    rdx(4'h5, 8'h04);
    bus(1'b1, 1'b0, 4'h6, 8'h07);
    rdx(4'h5, 8'h00);
    idle(2);
    $display("uart test done");
    results;
  end
endmodule // lrb_regs_tb
`default_nettype wire
